/* File: bench/smbmsc_peer.sv */
// Model of the SMBus slaves and the configuration EEPROM.
// Assumes the bench calls pulse from one process, one event at a time.
`timescale 1ns/1ps
module smbmsc_peer (
    input  wire logic clk_i,
    output logic      load_done_o,
    output logic      csum_bad_o,
    output logic      no_cfg_done_o,
    output logic      unmapped_o,
    output logic      arb_won_o,
    output logic      arb_lost_o,
    output logic      xfer_end_o,
    output logic      nack_o,
    output logic      misplaced_o
);
    logic [8:0] ev_r;

    initial ev_r = '0;
    assign load_done_o   = ev_r[0];
    assign csum_bad_o    = ev_r[1];
    assign no_cfg_done_o = ev_r[2];
    assign unmapped_o    = ev_r[3];
    assign arb_won_o     = ev_r[4];
    assign arb_lost_o    = ev_r[5];
    assign xfer_end_o    = ev_r[6];
    assign nack_o        = ev_r[7];
    assign misplaced_o   = ev_r[8];

    // Raises one event for exactly one clock cycle.
    task automatic pulse(input int k);
        @(posedge clk_i);
        ev_r[k] <= 1'b1;
        @(posedge clk_i);
        ev_r <= '0;
    endtask
endmodule

/* File: bench/smbus_master_status_control_tb.sv */
// Self-checking bench for the master SMBus status and control block.
// Assumes the AXI4-Lite slave timing given with the design.
`timescale 1ns/1ps
module smbus_master_status_control_tb;
    import smbmsc_pkg::*;
    logic        clk, rst_n, boot_fast, en, req, busy, irq, tick, abrt;
    logic        ce;
    logic        awvalid, wvalid, bready, arvalid, rready, arb_st;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v, b;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic        ld, cs, nc, um, aw, al, xe, nk, mp;
    int          err_total, tests_run, ticks, gap, last_gap;
    int          starts, aborts, t0;

    smbmsc_top smbmsc_top_i (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
        .BOOT_FAST_I(boot_fast), .EEPROM_INIT_EN_I(en),
        .EEPROM_LOAD_DONE_I(ld), .EEPROM_CSUM_BAD_I(cs),
        .EEPROM_NO_CFG_DONE_I(nc), .EEPROM_UNMAPPED_I(um),
        .XFER_REQ_I(req), .ARB_WON_I(aw), .ARB_LOST_I(al),
        .XFER_END_I(xe), .NACK_I(nk), .MISPLACED_I(mp),
        .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
        .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
        .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
        .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
        .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
        .RVALID_O(rvalid), .RREADY_I(rready), .PRESC_TICK_O(tick),
        .ARB_START_O(arb_st), .XFER_BUSY_O(busy),
        .XFER_ABORT_O(abrt), .IRQ_O(irq));

    smbmsc_peer smbmsc_peer_i (.clk_i(clk), .load_done_o(ld),
        .csum_bad_o(cs), .no_cfg_done_o(nc), .unmapped_o(um),
        .arb_won_o(aw), .arb_lost_o(al), .xfer_end_o(xe),
        .nack_o(nk), .misplaced_o(mp));

    // ------------------------------------------------------------------
    // Clock, monitor and helpers.
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        gap <= gap + 1;
        if (tick === 1'b1) begin
            last_gap <= gap + 1;
            gap      <= 0;
            ticks    <= ticks + 1;
        end
        if (arb_st === 1'b1) starts <= starts + 1;
        if (abrt === 1'b1) aborts <= aborts + 1;
    end

    task automatic chk(input string n, input logic [31:0] g, e);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        resp = bresp;
        bready <= 1'b0;
        if (n == 64) err_total++;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        int n;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (n == 64) err_total++;
    endtask

    task automatic rst(input logic f);
        @(posedge clk);
        boot_fast <= f;
        rst_n     <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    task automatic xreq();
        @(posedge clk);
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
    endtask

    task automatic finish_test();
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests.
    // ------------------------------------------------------------------
    initial begin
        {rst_n, boot_fast, en, req, awvalid, wvalid, bready} = '0;
        ce = 1'b1;
        {arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
        {err_total, tests_run, ticks, gap, last_gap, starts, aborts} = '0;
        rst(1'b0);
        rd(STATUS_OFF, v);
        chk("status", v, 32'h0);
        rd(CONTROL_OFF, v);
        chk("control", v, 32'h0000_0139);
        en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            smbmsc_peer_i.pulse(i);
            rd(STATUS_OFF, v);
            b = (i == 0) ? 32'h3f00_0000 : 32'h3e00_0000;
            chk("init flag", v & b, (i == 0) ? 32'h0100_0000 :
                (i == 3) ? 32'h2000_0000 : 32'h1000_0000);
            chk("irq masked", {31'h0, irq}, 32'h0);
            wr(STATUS_OFF, 32'h0, 4'hf);
            rd(STATUS_OFF, b);
            chk("zero write", b, v);
            wr(STATUS_OFF, 32'h3f00_0000, 4'h8);
            rd(STATUS_OFF, v);
            chk("cleared", v, 32'h0100_0000);
        end
        wr(CONTROL_OFF, 32'h0002_0000, 4'h4);
        smbmsc_peer_i.pulse(1);
        rd(STATUS_OFF, v);
        chk("csum ignored", v & 32'h1000_0000, 32'h0);
        wr(CONTROL_OFF, 32'h0, 4'h4);
        wr(STATUS_OFF, 32'h3f00_0000, 4'h8);
        for (int k = 7; k < 9; k++) begin
            b = (k == 7) ? 32'h0200_0000 : 32'h0800_0000;
            wr(IRQ_MASK_OFF, b, 4'hf);
            chk("write ok", {30'h0, resp}, 32'h0);
            rd(IRQ_MASK_OFF, v);
            chk("irq mask", v, b);
            chk("read ok", {30'h0, resp}, 32'h0);
            xreq();
            smbmsc_peer_i.pulse(4);
            smbmsc_peer_i.pulse(k);
            smbmsc_peer_i.pulse(6);
            rd(STATUS_OFF, v);
            chk("bus flag", v, b | 32'h0100_0000);
            chk("irq set", {31'h0, irq}, 32'h1);
            wr(STATUS_OFF, b, 4'h8);
            repeat (2) @(posedge clk);
            chk("irq clear", {31'h0, irq}, 32'h0);
        end
        xreq();
        repeat (3) @(posedge clk);
        t0 = starts;
        repeat (15) smbmsc_peer_i.pulse(5);
        repeat (3) @(posedge clk);
        chk("retries", starts - t0, 32'd15);
        chk("no abort", aborts, 32'd0);
        smbmsc_peer_i.pulse(5);
        repeat (3) @(posedge clk);
        chk("abort", aborts, 32'd1);
        rd(STATUS_OFF, v);
        chk("lost flag", v, 32'h0500_0000);
        wr(STATUS_OFF, v, 4'h8);
        wr(CONTROL_OFF, 32'h0001_0000, 4'h4);
        xreq();
        smbmsc_peer_i.pulse(5);
        repeat (2) @(posedge clk);
        chk("busy", {31'h0, busy}, 32'h1);
        smbmsc_peer_i.pulse(7);
        smbmsc_peer_i.pulse(6);
        rd(STATUS_OFF, v);
        chk("ignore masters", v, 32'h0300_0000);
        wr(STATUS_OFF, v, 4'h8);
        wr(CONTROL_OFF, 32'h0, 4'h4);
        for (int p = 0; p < 4; p++) begin
            wr(CONTROL_OFF, p, 4'h3);
            rd(CONTROL_OFF, v);
            chk("prescaler", v, p);
            t0 = ticks;
            repeat (64) @(posedge clk);
            if (p < 2) chk("stopped", ticks - t0, 32'd0);
            else chk("period", last_gap, p * 4);
        end
        ce <= 1'b0;
        t0 = starts;
        xreq();
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        chk("frozen", starts - t0, 32'd0);
        wr(12'h3fc, 32'hffff_ffff, 4'hf);
        chk("write resp", {30'h0, resp}, 32'h2);
        rd(12'h3fc, v);
        chk("read resp", {30'h0, resp}, 32'h2);
        en <= 1'b0;
        rst(1'b1);
        rd(CONTROL_OFF, v);
        chk("control fast", v, 32'h0000_0053);
        rd(STATUS_OFF, v);
        chk("status again", v, 32'h0);
        smbmsc_peer_i.pulse(0);
        smbmsc_peer_i.pulse(3);
        rd(STATUS_OFF, v);
        chk("init off", v, 32'h0);
        en <= 1'b1;
        smbmsc_peer_i.pulse(0);
        rd(STATUS_OFF, v);
        chk("init on", v, 32'h0100_0000);
        finish_test();
    end

    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        finish_test();
    end
endmodule

/* File: rtl/smbmsc_pkg.sv */
// Package for the master SMBus status and control block.
// Assumes a 32-bit AXI4-Lite register bus and one 125 MHz core clock.
package smbmsc_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] STATUS_OFF   = 12'h344;
    localparam logic [11:0] CONTROL_OFF  = 12'h348;
    localparam logic [11:0] IRQ_MASK_OFF = 12'h350;
    // ------------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------------
    localparam int INIT_DONE_BIT  = 24;
    localparam int NO_ACK_BIT     = 25;
    localparam int LOST_ARB_BIT   = 26;
    localparam int MISPLACED_BIT  = 27;
    localparam int CHECKSUM_BIT   = 28;
    localparam int UNMAPPED_BIT   = 29;
    localparam int ERR_LO         = 25;
    localparam int ERR_HI         = 29;
    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    localparam int IGN_MASTERS_BIT = 16;
    localparam int IGN_CHECKSUM_BIT = 17;
    localparam logic [15:0] PRESC_SLOW_RST = 16'h0139;
    localparam logic [15:0] PRESC_FAST_RST = 16'h0053;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 8;
    localparam int PRESC_UNIT_NS   = 32;
    localparam int PRESC_UNIT_CYC  = (PRESC_UNIT_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    localparam int ARB_RETRY_LIMIT = 16;
    // ------------------------------------------------------------------
    // AXI responses
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SMBMSC_IDLE = 2'b00,
        SMBMSC_ARB  = 2'b01,
        SMBMSC_XFER = 2'b10
    } smbmsc_state_t;
endpackage

/* File: rtl/smbmsc_top.sv */
// Status, control, prescaler and arbitration retry of the master SMBus.
// Assumes bus events and EEPROM-load events arrive as one-cycle pulses.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module smbmsc_top
    import smbmsc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              CLK_I,
    input  wire logic              RST_N_I,
    input  wire logic              CE_I,
    input  wire logic              BOOT_FAST_I,
    input  wire logic              EEPROM_INIT_EN_I,
    input  wire logic              EEPROM_LOAD_DONE_I,
    input  wire logic              EEPROM_CSUM_BAD_I,
    input  wire logic              EEPROM_NO_CFG_DONE_I,
    input  wire logic              EEPROM_UNMAPPED_I,
    input  wire logic              XFER_REQ_I,
    input  wire logic              ARB_WON_I,
    input  wire logic              ARB_LOST_I,
    input  wire logic              XFER_END_I,
    input  wire logic              NACK_I,
    input  wire logic              MISPLACED_I,
    input  wire logic [ADDR_W-1:0] AWADDR_I,
    input  wire logic              AWVALID_I,
    output logic                   AWREADY_O,
    input  wire logic [31:0]       WDATA_I,
    input  wire logic [3:0]        WSTRB_I,
    input  wire logic              WVALID_I,
    output logic                   WREADY_O,
    output logic [1:0]             BRESP_O,
    output logic                   BVALID_O,
    input  wire logic              BREADY_I,
    input  wire logic [ADDR_W-1:0] ARADDR_I,
    input  wire logic              ARVALID_I,
    output logic                   ARREADY_O,
    output logic [31:0]            RDATA_O,
    output logic [1:0]             RRESP_O,
    output logic                   RVALID_O,
    input  wire logic              RREADY_I,
    output logic                   PRESC_TICK_O,
    output logic                   ARB_START_O,
    output logic                   XFER_BUSY_O,
    output logic                   XFER_ABORT_O,
    output logic                   IRQ_O
);
    import smbmsc_pkg::*;

    initial begin
        if (ADDR_W < 12) begin
            $error("ADDR_W must be at least 12");
        end
    end

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [15:0]   presc_r;
    logic          ign_masters_r;
    logic          ign_csum_r;
    logic [5:0]    flags_r;
    logic [5:0]    flags_nxt;
    logic [5:0]    mask_r;
    logic          boot_seen_r;
    logic          aw_full_r;
    logic          w_full_r;
    logic [11:0]   aw_addr_r;
    logic [31:0]   w_data_r;
    logic [3:0]    w_strb_r;
    smbmsc_state_t state_r;
    smbmsc_state_t state_nxt;
    logic [4:0]    loss_cnt_r;
    logic [15:0]   presc_cnt_r;
    logic [1:0]    unit_cnt_r;

    // ------------------------------------------------------------------
    // Write channel decode
    // ------------------------------------------------------------------
    wire aw_take  = AWVALID_I && AWREADY_O;
    wire w_take   = WVALID_I && WREADY_O;
    wire wr_fire  = aw_full_r && w_full_r && !BVALID_O;
    wire wr_stat  = wr_fire && (aw_addr_r == STATUS_OFF);
    wire wr_ctrl  = wr_fire && (aw_addr_r == CONTROL_OFF);
    wire wr_mask  = wr_fire && (aw_addr_r == IRQ_MASK_OFF);
    wire wr_hit   = wr_stat || wr_ctrl || wr_mask;

    // ------------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------------
    wire lost_ev   = (state_r == SMBMSC_ARB) && ARB_LOST_I
                     && !ign_masters_r;
    wire abort_ev  = lost_ev && (loss_cnt_r == 5'(ARB_RETRY_LIMIT - 1));
    wire csum_ev   = EEPROM_INIT_EN_I && !ign_csum_r
                     && (EEPROM_CSUM_BAD_I || EEPROM_NO_CFG_DONE_I);
    wire unmap_ev  = EEPROM_INIT_EN_I && EEPROM_UNMAPPED_I;
    wire done_ev   = EEPROM_INIT_EN_I && (EEPROM_LOAD_DONE_I || csum_ev
                     || unmap_ev);
    wire in_xfer   = state_r == SMBMSC_XFER;
    wire [5:0] set_vec = {unmap_ev, csum_ev, in_xfer && MISPLACED_I,
                          abort_ev, in_xfer && NACK_I, done_ev};
    wire [5:0] clr_vec = (wr_stat && w_strb_r[3])
                         ? {w_data_r[UNMAPPED_BIT:NO_ACK_BIT], 1'b0}
                         : 6'h00;

    // Set beats clear in the same cycle.
    assign flags_nxt = (flags_r & ~clr_vec) | set_vec;

    // ------------------------------------------------------------------
    // Arbitration retry sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SMBMSC_IDLE: begin
                if (XFER_REQ_I) begin
                    state_nxt = SMBMSC_ARB;
                end
            end
            SMBMSC_ARB: begin
                if (ARB_WON_I || (ARB_LOST_I && ign_masters_r)) begin
                    state_nxt = SMBMSC_XFER;
                end else if (abort_ev) begin
                    state_nxt = SMBMSC_IDLE;
                end
            end
            SMBMSC_XFER: begin
                if (XFER_END_I) begin
                    state_nxt = SMBMSC_IDLE;
                end
            end
            default: state_nxt = SMBMSC_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    wire presc_run  = presc_r > 16'h0001;
    wire unit_tick  = unit_cnt_r == 2'(PRESC_UNIT_CYC - 1);
    wire presc_wrap = unit_tick && (presc_cnt_r >= presc_r - 16'h0001);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    wire [31:0] stat_word = {2'h0, flags_r, 24'h000000};
    wire [31:0] ctrl_word = {14'h0000, ign_csum_r, ign_masters_r, presc_r};
    wire [31:0] mask_word = {2'h0, mask_r, 24'h000000};
    wire [11:0] ar_addr   = ARADDR_I[11:0];
    wire        rd_hit    = (ar_addr == STATUS_OFF)
                            || (ar_addr == CONTROL_OFF)
                            || (ar_addr == IRQ_MASK_OFF);
    wire [31:0] rd_word   = (ar_addr == STATUS_OFF) ? stat_word
                          : (ar_addr == CONTROL_OFF) ? ctrl_word
                          : (ar_addr == IRQ_MASK_OFF) ? mask_word : 32'h0;

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            aw_addr_r <= 12'h000;
            w_data_r  <= 32'h0;
            w_strb_r  <= 4'h0;
            AWREADY_O <= 1'b0;
            WREADY_O  <= 1'b0;
            BVALID_O  <= 1'b0;
            BRESP_O   <= RESP_OKAY;
            ARREADY_O <= 1'b0;
            RVALID_O  <= 1'b0;
            RRESP_O   <= RESP_OKAY;
            RDATA_O   <= 32'h0;
        end else if (CE_I) begin
            AWREADY_O <= !aw_full_r && !aw_take && !BVALID_O;
            WREADY_O  <= !w_full_r && !w_take && !BVALID_O;
            if (aw_take) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= AWADDR_I[11:0];
            end
            if (w_take) begin
                w_full_r <= 1'b1;
                w_data_r <= WDATA_I;
                w_strb_r <= WSTRB_I;
            end
            if (wr_fire) begin
                aw_full_r <= 1'b0;
                w_full_r  <= 1'b0;
                BVALID_O  <= 1'b1;
                BRESP_O   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (BVALID_O && BREADY_I) begin
                BVALID_O  <= 1'b0;
            end
            ARREADY_O <= !ARVALID_I || ARREADY_O ? !RVALID_O && !ARREADY_O
                                                 : !RVALID_O;
            if (ARVALID_I && ARREADY_O) begin
                ARREADY_O <= 1'b0;
                RVALID_O  <= 1'b1;
                RDATA_O   <= rd_word;
                RRESP_O   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (RVALID_O && RREADY_I) begin
                RVALID_O  <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control, status and mask registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            presc_r       <= 16'h0000;
            boot_seen_r   <= 1'b0;
            ign_masters_r <= 1'b0;
            ign_csum_r    <= 1'b0;
            flags_r       <= 6'h00;
            mask_r        <= 6'h00;
            IRQ_O         <= 1'b0;
        end else if (CE_I) begin
            if (!boot_seen_r) begin
                boot_seen_r <= 1'b1;
                presc_r     <= BOOT_FAST_I ? PRESC_FAST_RST
                                           : PRESC_SLOW_RST;
            end else if (wr_ctrl) begin
                if (w_strb_r[0]) begin
                    presc_r[7:0] <= w_data_r[7:0];
                end
                if (w_strb_r[1]) begin
                    presc_r[15:8] <= w_data_r[15:8];
                end
                if (w_strb_r[2]) begin
                    ign_masters_r <= w_data_r[IGN_MASTERS_BIT];
                    ign_csum_r    <= w_data_r[IGN_CHECKSUM_BIT];
                end
            end
            if (wr_mask && w_strb_r[3]) begin
                mask_r <= w_data_r[UNMAPPED_BIT:INIT_DONE_BIT];
            end
            flags_r <= flags_nxt;
            IRQ_O   <= |(flags_nxt & mask_r);
        end
    end

    // ------------------------------------------------------------------
    // Sequencer and prescaler state
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_r      <= SMBMSC_IDLE;
            loss_cnt_r   <= 5'h00;
            presc_cnt_r  <= 16'h0000;
            unit_cnt_r   <= 2'h0;
            PRESC_TICK_O <= 1'b0;
            ARB_START_O  <= 1'b0;
            XFER_BUSY_O  <= 1'b0;
            XFER_ABORT_O <= 1'b0;
        end else if (CE_I) begin
            state_r      <= state_nxt;
            ARB_START_O  <= (state_nxt == SMBMSC_ARB)
                            && ((state_r != SMBMSC_ARB) || lost_ev);
            XFER_BUSY_O  <= state_nxt == SMBMSC_XFER;
            XFER_ABORT_O <= abort_ev;
            if (state_r != SMBMSC_ARB) begin
                loss_cnt_r <= 5'h00;
            end else if (lost_ev) begin
                loss_cnt_r <= loss_cnt_r + 5'h01;
            end
            if (!presc_run) begin
                unit_cnt_r   <= 2'h0;
                presc_cnt_r  <= 16'h0000;
                PRESC_TICK_O <= 1'b0;
            end else begin
                unit_cnt_r   <= unit_tick ? 2'h0 : unit_cnt_r + 2'h1;
                PRESC_TICK_O <= presc_wrap;
                if (presc_wrap) begin
                    presc_cnt_r <= 16'h0000;
                end else if (unit_tick) begin
                    presc_cnt_r <= presc_cnt_r + 16'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking chk_cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    chk_abort_sets_flag: assert property (
        CE_I && abort_ev
        |=> flags_r[LOST_ARB_BIT-INIT_DONE_BIT] && XFER_ABORT_O)
        else $error("abort did not set lost arbitration flag");
    chk_retry_after_loss: assert property (
        CE_I && lost_ev && !abort_ev |=> ARB_START_O)
        else $error("no retry after lost arbitration");
    chk_ignore_masters: assert property (
        CE_I && state_r == SMBMSC_ARB && ARB_LOST_I && ign_masters_r
        |=> state_r == SMBMSC_XFER)
        else $error("ignore masters did not continue");
    chk_nack_flag: assert property (
        CE_I && in_xfer && NACK_I |=> flags_r[NO_ACK_BIT-INIT_DONE_BIT])
        else $error("nack flag not set");
    chk_misplaced_flag: assert property (
        CE_I && in_xfer && MISPLACED_I
        |=> flags_r[MISPLACED_BIT-INIT_DONE_BIT])
        else $error("misplaced condition flag not set");
    chk_csum_ignored: assert property (
        CE_I && ign_csum_r && !$past(flags_r[CHECKSUM_BIT-INIT_DONE_BIT])
        && !flags_r[CHECKSUM_BIT-INIT_DONE_BIT]
        |=> !flags_r[CHECKSUM_BIT-INIT_DONE_BIT])
        else $error("checksum flag set while ignored");
    chk_set_beats_clear: assert property (
        CE_I && csum_ev |=> flags_r[CHECKSUM_BIT-INIT_DONE_BIT])
        else $error("checksum event lost");
    chk_unmapped_flag: assert property (
        CE_I && unmap_ev
        |=> flags_r[UNMAPPED_BIT-INIT_DONE_BIT] && flags_r[0])
        else $error("unmapped flag or done flag not set");
    chk_presc_halt: assert property (
        CE_I && presc_r < 16'h0002 |=> !PRESC_TICK_O)
        else $error("prescaler ticked while stopped");
    chk_done_on_load: assert property (
        CE_I && EEPROM_INIT_EN_I && EEPROM_LOAD_DONE_I |=> flags_r[0])
        else $error("init complete flag not set");
    cov_abort: cover property (abort_ev);
    cov_xfer: cover property (state_r == SMBMSC_XFER);
    cov_tick: cover property (PRESC_TICK_O);
    cov_ignore: cover property (ARB_LOST_I && ign_masters_r);
endmodule
